/* verilog/sff_slot_cfg.sv */
// Slot FIFO format, trigger source and sample clock configuration,
// reached over the two-wire serial control port.
// Assumes open-drain pins resolved outside; pins are asynchronous.
`timescale 1ns/1ps
`include "sff_consts.svh"
module sff_slot_cfg import sff_pkg::*;
(
   input  wire logic        CLOCK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE_O,
   input  wire logic        SYNC_PIN_I,
   output logic             SYNC_PIN_O,
   output logic             SYNC_PIN_OE_O,
   input  wire logic        EXT_TRIG_I,
   input  wire logic        DIG_INT_MODE_I,
   input  wire logic        SAMPLE_VALID_I,
   input  wire logic [31:0] SAMPLE_CH0_I,
   input  wire logic [31:0] SAMPLE_CH1_I,
   input  wire logic [31:0] SAMPLE_CH2_I,
   input  wire logic [31:0] SAMPLE_CH3_I,
   input  wire logic [31:0] SAMPLE_BG_I,
   input  wire logic        FIFO_READY_I,
   output logic             SLOT_ACTIVE_O,
   output logic             SAMPLE_START_O,
   output logic             FIFO_VALID_O,
   output logic [15:0]      FIFO_DATA_O
);

   localparam logic [10:0] OSC_LAST = 11'(`SFF_OSC_CYC - 1);
   localparam logic [10:0] OSC_HALF = 11'(`SFF_OSC_CYC / 2);

   // Pin synchronisers: 0 SCL, 1 SDA, 2 sync pin, 3 external trigger
   logic [3:0]   pin_raw;
   logic [3:0]   pin_meta;
   logic [3:0]   pin_s;
   logic [3:0]   pin_d;

   logic [15:0]  slot_cfg;
   logic [15:0]  trig_cfg;
   logic [15:0]  clk_cfg;

   sff_i2c_st_t  state;
   logic [7:0]   shreg;
   logic [3:0]   bit_cnt;
   logic [1:0]   byte_idx;
   logic         rw;
   logic         tx_lo;
   logic [7:0]   reg_ptr;
   logic [7:0]   data_hi;
   logic         sda_oe;

   logic         scl_rise;
   logic         scl_fall;
   logic         start_ev;
   logic         stop_ev;
   logic         wr_fire;
   logic [15:0]  rd_word;
   logic [7:0]   tx_next;

   logic [10:0]  osc_cnt;
   logic         osc_lvl;
   logic         int_tick;
   logic         sample_tick;
   logic         trig_rise;
   logic         start_q;

   logic         slot_en;
   logic         ext_sel;
   logic         osc_byp;

   assign pin_raw = {EXT_TRIG_I, SYNC_PIN_I, SDA_I, SCL_I};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_sync
         always_ff @(posedge CLOCK_I)
         begin
            if (SYS_RST_I)
            begin
               pin_meta[gi] <= 1'b1;
               pin_s[gi]    <= 1'b1;
               pin_d[gi]    <= 1'b1;
            end
            else
            begin
               pin_meta[gi] <= pin_raw[gi];
               pin_s[gi]    <= pin_meta[gi];
               pin_d[gi]    <= pin_s[gi];
            end
         end
      end
   endgenerate

   assign scl_rise = pin_s[0] & ~pin_d[0];
   assign scl_fall = ~pin_s[0] & pin_d[0];
   assign start_ev = pin_s[0] & pin_d[0] & ~pin_s[1] & pin_d[1];
   assign stop_ev  = pin_s[0] & pin_d[0] & pin_s[1] & ~pin_d[1];

   assign slot_en = slot_cfg[`SFF_SLOT_EN_BIT];
   assign ext_sel = trig_cfg[`SFF_EXT_TRIG_BIT];
   assign osc_byp = clk_cfg[`SFF_OSC_BYP_BIT];

   function automatic logic [15:0] rd_reg(input logic [7:0] ptr);
      case (ptr)
         `SFF_REG_SLOT_CFG: rd_reg = slot_cfg;
         `SFF_REG_TRIG:     rd_reg = trig_cfg;
         `SFF_REG_CLK:      rd_reg = clk_cfg;
         default:           rd_reg = 16'h0000;
      endcase
   endfunction

   assign rd_word = rd_reg(reg_ptr);
   assign tx_next = tx_lo ? rd_word[15:8] : rd_word[7:0];
   assign wr_fire = (state == ST_RXB) && scl_fall && (bit_cnt == 4'h8)
                    && (byte_idx == 2'h2) && !start_ev && !stop_ev;

   // Serial control port: address, register pointer, then 16-bit words
   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
      begin
         state    <= ST_IDLE;
         shreg    <= 8'h00;
         bit_cnt  <= 4'h0;
         byte_idx <= 2'h0;
         rw       <= 1'b0;
         tx_lo    <= 1'b0;
         reg_ptr  <= 8'h00;
         data_hi  <= 8'h00;
         sda_oe   <= 1'b0;
      end
      else if (start_ev)
      begin
         state   <= ST_ADDR;
         bit_cnt <= 4'h0;
         sda_oe  <= 1'b0;
      end
      else if (stop_ev)
      begin
         state  <= ST_IDLE;
         sda_oe <= 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               sda_oe <= 1'b0;
            end
            ST_ADDR, ST_RXB:
            begin
               if (scl_rise)
               begin
                  shreg   <= {shreg[6:0], pin_s[1]};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else if (scl_fall && (bit_cnt == 4'h8))
               begin
                  bit_cnt <= 4'h0;
                  if (state == ST_ADDR)
                  begin
                     if (shreg[7:1] == `SFF_I2C_ADDR)
                     begin
                        rw       <= shreg[0];
                        byte_idx <= 2'h0;
                        tx_lo    <= 1'b0;
                        sda_oe   <= 1'b1;
                        state    <= ST_ACK;
                     end
                     else
                        state <= ST_IDLE;
                  end
                  else
                  begin
                     sda_oe <= 1'b1;
                     state  <= ST_ACK;
                     if (byte_idx == 2'h0)
                     begin
                        reg_ptr  <= shreg;
                        byte_idx <= 2'h1;
                     end
                     else if (byte_idx == 2'h1)
                     begin
                        data_hi  <= shreg;
                        byte_idx <= 2'h2;
                     end
                     else
                        byte_idx <= 2'h1;
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  bit_cnt <= 4'h0;
                  if (rw)
                  begin
                     shreg  <= rd_word[15:8];
                     sda_oe <= ~rd_word[15];
                     state  <= ST_TXB;
                  end
                  else
                  begin
                     sda_oe <= 1'b0;
                     state  <= ST_RXB;
                  end
               end
            end
            ST_TXB:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt == 4'h7)
                  begin
                     sda_oe <= 1'b0;
                     state  <= ST_RACK;
                  end
                  else
                  begin
                     shreg   <= {shreg[6:0], 1'b0};
                     sda_oe  <= ~shreg[6];
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            ST_RACK:
            begin
               if (scl_rise && pin_s[1])
                  state <= ST_IDLE;
               else if (scl_fall)
               begin
                  tx_lo   <= ~tx_lo;
                  shreg   <= tx_next;
                  sda_oe  <= ~tx_next[7];
                  bit_cnt <= 4'h0;
                  state   <= ST_TXB;
               end
            end
            default:
            begin
               state  <= ST_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   assign SDA_O    = 1'b0;
   assign SDA_OE_O = sda_oe;

   // Register file
   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
      begin
         slot_cfg <= `SFF_SLOT_CFG_RST;
         trig_cfg <= `SFF_TRIG_RST;
         clk_cfg  <= `SFF_CLK_RST;
      end
      else if (wr_fire)
      begin
         case (reg_ptr)
            `SFF_REG_SLOT_CFG: slot_cfg <= {data_hi, shreg};
            `SFF_REG_TRIG:     trig_cfg <= {data_hi, shreg};
            `SFF_REG_CLK:      clk_cfg  <= {data_hi, shreg};
            default:           slot_cfg <= slot_cfg;
         endcase
      end
   end

   // Internal 32 kHz sample oscillator
   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
      begin
         osc_cnt <= 11'h000;
         osc_lvl <= 1'b0;
      end
      else
      begin
         osc_cnt <= (osc_cnt == OSC_LAST) ? 11'h000 : osc_cnt + 11'h001;
         osc_lvl <= (osc_cnt < OSC_HALF);
      end
   end

   assign int_tick      = (osc_cnt == OSC_LAST);
   assign sample_tick   = osc_byp ? (pin_s[2] & ~pin_d[2]) : int_tick;
   assign trig_rise     = pin_s[3] & ~pin_d[3];
   assign SYNC_PIN_O    = osc_lvl;
   assign SYNC_PIN_OE_O = ~osc_byp;

   // Sample start: sample clock (internal or sync pin) or external trigger
   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I)
         start_q <= 1'b0;
      else
         start_q <= slot_en && (ext_sel ? trig_rise : sample_tick);
   end

   assign SAMPLE_START_O = start_q;
   assign SLOT_ACTIVE_O  = slot_en;

   sff_packer u_packer
   (
      .clk_i     (CLOCK_I),
      .rst_i     (SYS_RST_I),
      .valid_i   (SAMPLE_VALID_I & slot_en),
      .dig_int_i (DIG_INT_MODE_I),
      .format_i  (slot_cfg[`SFF_FMT_MSB:`SFF_FMT_LSB]),
      .ch0_i     (SAMPLE_CH0_I),
      .ch1_i     (SAMPLE_CH1_I),
      .ch2_i     (SAMPLE_CH2_I),
      .ch3_i     (SAMPLE_CH3_I),
      .bg_i      (SAMPLE_BG_I),
      .ready_i   (FIFO_READY_I),
      .valid_o   (FIFO_VALID_O),
      .data_o    (FIFO_DATA_O)
   );

endmodule

/* verilog/sff_consts.svh */
// Register offsets, field positions, reset values and timing counts
// for the slot FIFO format and trigger configuration block.
// Assumes inclusion by bare name from the design files.
`ifndef SFF_CONSTS_SVH
`define SFF_CONSTS_SVH

// Serial control port target address (arbitrary value)
`define SFF_I2C_ADDR        7'h64

`define SFF_REG_SLOT_CFG    8'h11
`define SFF_REG_TRIG        8'h38
`define SFF_REG_CLK         8'h4B

`define SFF_SLOT_CFG_RST    16'h1000
`define SFF_TRIG_RST        16'h0000
`define SFF_CLK_RST         16'h2612

`define SFF_FMT_MSB         4
`define SFF_FMT_LSB         2
`define SFF_SLOT_EN_BIT     0
`define SFF_EXT_TRIG_BIT    14
`define SFF_OSC_BYP_BIT     8

`define SFF_CLK_HZ          32'h0262_5A00
`define SFF_OSC_HZ          32'h0000_7D00
`define SFF_OSC_CYC         (`SFF_CLK_HZ / `SFF_OSC_HZ)

`endif

/* verilog/sff_pkg.sv */
// Types shared by the slot FIFO format and trigger configuration block.
// Assumes the constants header is compiled alongside.
package sff_pkg;

   typedef enum logic [2:0]
   {
      FMT_NONE     = 3'h0,
      FMT_W16      = 3'h1,
      FMT_W32      = 3'h2,
      FMT_SB16     = 3'h3,
      FMT_SB32_Q16 = 3'h4,
      FMT_Q32      = 3'h6
   } sff_fmt_t;

   typedef enum logic [5:0]
   {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_RXB  = 6'h04,
      ST_ACK  = 6'h08,
      ST_TXB  = 6'h10,
      ST_RACK = 6'h20
   } sff_i2c_st_t;

endpackage

/* verilog/sff_packer.sv */
// Packs one time slot sample into 16-bit FIFO words per the format code.
// Assumes sample data and the integration mode flag share the clock.
`timescale 1ns/1ps
module sff_packer import sff_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        valid_i,
   input  wire logic        dig_int_i,
   input  wire logic [2:0]  format_i,
   input  wire logic [31:0] ch0_i,
   input  wire logic [31:0] ch1_i,
   input  wire logic [31:0] ch2_i,
   input  wire logic [31:0] ch3_i,
   input  wire logic [31:0] bg_i,
   input  wire logic        ready_i,
   output logic             valid_o,
   output logic [15:0]      data_o
);

   logic [127:0] frame;
   logic [3:0]   words;
   logic [127:0] next_frame;
   logic [3:0]   next_words;
   logic [31:0]  sum4;
   logic [31:0]  single;
   logic         load_ok;

   assign sum4    = ch0_i + ch1_i + ch2_i + ch3_i;
   assign single  = dig_int_i ? ch0_i : sum4;
   assign valid_o = (words != 4'h0);
   assign data_o  = frame[127:112];
   assign load_ok = (words == 4'h0) || ((words == 4'h1) && ready_i);

   always_comb
   begin
      next_frame = 128'h0;
      next_words = 4'h0;
      case (format_i)
         FMT_W16:
         begin
            next_frame = {single[15:0], 112'h0};
            next_words = 4'h1;
         end
         FMT_W32:
         begin
            next_frame = {single, 96'h0};
            next_words = 4'h2;
         end
         FMT_SB16:
         begin
            if (dig_int_i)
            begin
               next_frame = {ch0_i[15:0], bg_i[15:0], 96'h0};
               next_words = 4'h2;
            end
         end
         FMT_SB32_Q16:
         begin
            if (dig_int_i)
               next_frame = {ch0_i, bg_i, 64'h0};
            else
               next_frame = {ch0_i[15:0], ch1_i[15:0], ch2_i[15:0],
                             ch3_i[15:0], 64'h0};
            next_words = 4'h4;
         end
         FMT_Q32:
         begin
            if (!dig_int_i)
            begin
               next_frame = {ch0_i, ch1_i, ch2_i, ch3_i};
               next_words = 4'h8;
            end
         end
         default:
         begin
            next_frame = 128'h0;
            next_words = 4'h0;
         end
      endcase
   end

   // A sample arriving while the previous one still drains is dropped, unless its last word is taken that cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         frame <= 128'h0;
         words <= 4'h0;
      end
      else if (valid_i && load_ok)
      begin
         frame <= next_frame;
         words <= next_words;
      end
      else if (valid_o && ready_i)
      begin
         frame <= {frame[111:0], 16'h0};
         words <= words - 4'h1;
      end
   end

endmodule

/* tb/sff_slot_cfg_monitor.sv */
// Port-level checker for the slot configuration block.
// Assumes it is bound into sff_slot_cfg and sees only its ports.
`timescale 1ns/1ps
module sff_slot_cfg_monitor
(
   input wire logic        CLOCK_I,
   input wire logic        SYS_RST_I,
   input wire logic        SDA_OE_O,
   input wire logic        SYNC_PIN_O,
   input wire logic        SYNC_PIN_OE_O,
   input wire logic        SAMPLE_VALID_I,
   input wire logic        FIFO_READY_I,
   input wire logic        SLOT_ACTIVE_O,
   input wire logic        SAMPLE_START_O,
   input wire logic        FIFO_VALID_O,
   input wire logic [15:0] FIFO_DATA_O
);
   logic [10:0] per;
   logic        seen;

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SYS_RST_I);

   // Cycles since the last rise of the internal oscillator
   always_ff @(posedge CLOCK_I)
   begin
      if (SYS_RST_I || !SYNC_PIN_OE_O)
      begin
         per  <= 11'h000;
         seen <= 1'b0;
      end
      else if ($rose(SYNC_PIN_O))
      begin
         per  <= 11'h000;
         seen <= 1'b1;
      end
      else
      begin
         per <= per + 11'h001;
      end
   end

   AST_RST_BYP: assert property ($fell(SYS_RST_I) |-> SYNC_PIN_OE_O && !SDA_OE_O)
      else $error("bypass or data pull set after reset");
   AST_RST_SLOT: assert property ($fell(SYS_RST_I) |-> !SLOT_ACTIVE_O && !FIFO_VALID_O)
      else $error("slot active after reset");
   AST_START_ONE: assert property (SAMPLE_START_O |=> !SAMPLE_START_O)
      else $error("sample start longer than one cycle");
   AST_START_GATED: assert property (SAMPLE_START_O |-> $past(SLOT_ACTIVE_O))
      else $error("sample start with slot disabled");
   AST_FIFO_HOLD: assert property (FIFO_VALID_O && !FIFO_READY_I |=>
      FIFO_VALID_O && $stable(FIFO_DATA_O))
      else $error("word lost while stalled");
   AST_FIFO_CAUSE: assert property ($rose(FIFO_VALID_O) |->
      $past(SAMPLE_VALID_I) && $past(SLOT_ACTIVE_O))
      else $error("words without an enabled sample");
   AST_SLOT_OFF: assert property (!SLOT_ACTIVE_O && !FIFO_VALID_O |=> !FIFO_VALID_O)
      else $error("words from a disabled slot");
   AST_OSC_PERIOD: assert property ($rose(SYNC_PIN_O) && seen |-> per == 11'h4E1)
      else $error("internal oscillator period wrong");
endmodule
bind sff_slot_cfg sff_slot_cfg_monitor mon
(
   .CLOCK_I, .SYS_RST_I, .SDA_OE_O, .SYNC_PIN_O, .SYNC_PIN_OE_O, .SAMPLE_VALID_I,
   .FIFO_READY_I, .SLOT_ACTIVE_O, .SAMPLE_START_O, .FIFO_VALID_O, .FIFO_DATA_O
);

/* tb/sff_host_model.sv */
// Host model: two-wire control port master with open-drain data pull.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`include "sff_consts.svh"
module sff_host_model
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_pull_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end

   task automatic gap;
      repeat (5) @(negedge clk_i);
   endtask

   task automatic start;
      gap;
      sda_pull_o = 1'b0;
      gap;
      scl_o = 1'b1;
      gap;
      sda_pull_o = 1'b1;
      gap;
      scl_o = 1'b0;
   endtask

   task automatic stop;
      gap;
      sda_pull_o = 1'b1;
      gap;
      scl_o = 1'b1;
      gap;
      sda_pull_o = 1'b0;
      gap;
   endtask

   task automatic bitx(input logic b, output logic r);
      gap;
      sda_pull_o = !b;
      gap;
      scl_o = 1'b1;
      gap;
      r = sda_i;
      scl_o = 1'b0;
   endtask

   // Ninth bit: nb released reads the device ack, nb low acks a read byte
   task automatic xfer(input logic [7:0] tx, input logic nb, output logic [7:0] rx,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(tx[i], r);
         rx[i] = r;
      end
      bitx(nb, r);
      ack = !r;
   endtask

   task automatic access(input logic rd, input logic [7:0] p, input logic [15:0] wv,
                         output logic [15:0] rv, output logic ok);
      logic [7:0] rx;
      logic       a, b, c, d;
      rv = 16'h0000;
      start;
      xfer({`SFF_I2C_ADDR, 1'b0}, 1'b1, rx, a);
      xfer(p, 1'b1, rx, b);
      if (rd)
      begin
         start;
         xfer({`SFF_I2C_ADDR, 1'b1}, 1'b1, rx, c);
         xfer(8'hFF, 1'b0, rv[15:8], d);
         xfer(8'hFF, 1'b1, rv[7:0], d);
      end
      else
      begin
         xfer(wv[15:8], 1'b1, rx, c);
         xfer(wv[7:0], 1'b1, rx, d);
      end
      stop;
      ok = a & b & c & (rd | d);
   endtask
endmodule

/* tb/tb_slot_fifo_format_trigger_config.sv */
// Self-checking bench for slot format, trigger and sample clock settings.
// Assumes the host model drives the control port; data line has a pull-up.
`timescale 1ns/1ps
`include "sff_consts.svh"
module tb_slot_fifo_format_trigger_config;
   logic        clk, rst, scl, pull, sda_oe, sda_o, sync_o, sync_oe, sync_ext;
   logic        ext_trig, di, sv, rdy, active, start_o, fv;
   logic [31:0] ch [4];
   logic [31:0] bg;
   logic [15:0] fd;
   int          mismatches;
   int          num_checks;
   wire         sda = !(sda_oe && !sda_o) && !pull;
   wire         sync_pin = sync_oe ? sync_o : sync_ext;

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   sff_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));

   sff_slot_cfg dut
   (
      .CLOCK_I(clk), .SYS_RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
      .SDA_OE_O(sda_oe), .SYNC_PIN_I(sync_pin), .SYNC_PIN_O(sync_o),
      .SYNC_PIN_OE_O(sync_oe), .EXT_TRIG_I(ext_trig), .DIG_INT_MODE_I(di),
      .SAMPLE_VALID_I(sv), .SAMPLE_CH0_I(ch[0]), .SAMPLE_CH1_I(ch[1]),
      .SAMPLE_CH2_I(ch[2]), .SAMPLE_CH3_I(ch[3]), .SAMPLE_BG_I(bg),
      .FIFO_READY_I(rdy), .SLOT_ACTIVE_O(active), .SAMPLE_START_O(start_o),
      .FIFO_VALID_O(fv), .FIFO_DATA_O(fd)
   );

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      num_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic rw(input logic r, input logic [7:0] p, input logic [15:0] v);
      logic [15:0] got;
      logic        ok;
      host.access(r, p, v, got, ok);
      chk(ok, 1'b1, "no ack");
      if (r)
         chk(got, v, "reg read");
   endtask

   task automatic seen(input int n, input logic e, input string m);
      logic h;
      h = 1'b0;
      repeat (n)
      begin
         @(negedge clk);
         h = h | start_o;
      end
      chk(h, e, m);
   endtask

   task automatic pack(input logic [2:0] c, input logic d, output logic [15:0] q[$]);
      logic [31:0] s;
      logic [31:0] v;
      s = ch[0] + ch[1] + ch[2] + ch[3];
      v = d ? ch[0] : s;
      q = {};
      case (c)
         3'h1: q = {v[15:0]};
         3'h2: q = {v[31:16], v[15:0]};
         3'h3: if (d) q = {ch[0][15:0], bg[15:0]};
         3'h4: if (d) q = {ch[0][31:16], ch[0][15:0], bg[31:16], bg[15:0]};
               else q = {ch[0][15:0], ch[1][15:0], ch[2][15:0], ch[3][15:0]};
         3'h6: if (!d) foreach (ch[i]) q = {q, ch[i][31:16], ch[i][15:0]};
         default: q = {};
      endcase
   endtask

   // One sample through the packer while the FIFO stalls every other cycle
   task automatic run(input logic [2:0] c, input logic d, input logic en);
      logic [15:0] q[$];
      logic [15:0] got[$];
      di = d;
      rw(1'b0, `SFF_REG_SLOT_CFG, {11'h080, c, 1'b0, en});
      pack(c, d, q);
      if (!en)
         q = {};
      @(negedge clk);
      sv = 1'b1;
      for (int k = 0; k < 40; k++)
      begin
         @(negedge clk);
         sv = 1'b0;
         rdy = k[0];
         if (fv === 1'b1 && rdy)
            got.push_back(fd);
      end
      chk(got.size(), q.size(), "word count");
      foreach (q[i])
         chk(got[i], q[i], "word");
   endtask

   task automatic t_regs;
      logic [7:0] rx;
      logic       a;
      rw(1'b1, `SFF_REG_SLOT_CFG, 16'h1000);
      rw(1'b1, `SFF_REG_TRIG, 16'h0000);
      rw(1'b1, `SFF_REG_CLK, 16'h2612);
      rw(1'b1, 8'h20, 16'h0000);
      host.start;
      host.xfer(8'hA0, 1'b1, rx, a);
      host.stop;
      chk(a, 1'b0, "foreign address acked");
      rw(1'b0, `SFF_REG_SLOT_CFG, 16'h1011);
      rw(1'b1, `SFF_REG_SLOT_CFG, 16'h1011);
      chk(active, 1'b1, "slot not active");
   endtask

   task automatic t_formats;
      for (int c = 0; c < 8; c++)
      begin
         for (int d = 0; d < 2; d++)
         begin
            // Reserved format codes are never programmed
            if (c != 5 && c != 7)
               run(c[2:0], d[0], 1'b1);
         end
      end
      run(3'h1, 1'b0, 1'b0);
   endtask

   task automatic t_trigger;
      rw(1'b0, `SFF_REG_SLOT_CFG, 16'h1001);
      seen(1300, 1'b1, "no internal start");
      rw(1'b0, `SFF_REG_TRIG, 16'h4000); // Host picks external trigger first
      seen(1300, 1'b0, "internal start");
      ext_trig = 1'b1;
      seen(12, 1'b1, "no external start");
      ext_trig = 1'b0;
      rw(1'b0, `SFF_REG_SLOT_CFG, 16'h1000);
      ext_trig = 1'b1;
      seen(12, 1'b0, "start with slot off");
      ext_trig = 1'b0;
      rw(1'b0, `SFF_REG_TRIG, 16'h0000);
   endtask

   task automatic t_bypass;
      rw(1'b0, `SFF_REG_SLOT_CFG, 16'h1001);
      rw(1'b0, `SFF_REG_CLK, 16'h2712);
      chk(sync_oe, 1'b0, "sync pin driven");
      seen(1300, 1'b0, "start without clock");
      sync_ext = 1'b1;
      seen(12, 1'b1, "no start on sync edge");
      sync_ext = 1'b0;
      rw(1'b0, `SFF_REG_CLK, 16'h2612);
      chk(sync_oe, 1'b1, "sync pin released");
      seen(1300, 1'b1, "no internal start");
   endtask

   initial
   begin
      rst = 1'b1;
      {sync_ext, ext_trig, di, sv, rdy} = 5'h00;
      ch = '{32'h1111_8001, 32'h2222_8002, 32'h3333_8003, 32'h4444_8004};
      bg = 32'h5555_9009;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      t_regs;
      t_formats;
      t_trigger;
      t_bypass;
      tally_and_finish;
   end
endmodule
